// file: cit_pkg.sv
package cit_pkg;

  // ********************************************************************
  // Bus geometry
  // ********************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_EXT = 5;
  localparam int NUM_TRAP = 4;
  localparam int EV_W = NUM_EXT + NUM_TRAP;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [3:0] CORE_CONTROL_OFS = 4'h0;
  localparam logic [3:0] INTERRUPT_CONTROL_ONE_OFS = 4'h1;
  localparam logic [3:0] INTERRUPT_CONTROL_TWO_OFS = 4'h2;
  localparam logic [3:0] ARITH_STATUS_OFS = 4'h3;
  localparam logic [3:0] EVENT_STATUS_OFS = 4'h4;
  localparam logic [3:0] EVENT_MASK_OFS = 4'h5;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CC_TOP_BIT = 3;
  localparam int CC_RSVD_BIT = 2;
  localparam int IC1_NEST_BIT = 15;
  localparam int IC1_TRAP_LSB = 1;
  localparam int IC1_TRAP_MSB = 4;
  localparam int IC2_ALT_BIT = 15;
  localparam int IC2_DISABLE_INSTRUCTION_ACTIVE_BIT = 14;
  localparam int IC2_POL_LSB = 0;
  localparam int IC2_POL_MSB = 4;
  localparam int SR_IPL_LSB = 5;
  localparam int SR_IPL_MSB = 7;
  localparam int EV_TRAP_LSB = 5;

  // ********************************************************************
  // Values after reset and fixed codes
  // ********************************************************************
  localparam logic [3:0] LEVEL_RESET = 4'h0;
  localparam logic [2:0] LOW_BITS_USER_OFF = 3'h7;
  localparam logic [3:0] LEVEL_TOP_THRESHOLD = 4'h7;
  localparam logic [NUM_EXT-1:0] POL_RESET = 5'h00;
  localparam logic [NUM_TRAP-1:0] TRAP_RESET = 4'h0;
  localparam logic [EV_W-1:0] EV_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

endpackage

// file: cit_trap_control.sv
`timescale 1ns/10ps
module cit_trap_control
  import cit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_TRAP-1:0] trap_event,
  input wire logic [NUM_EXT-1:0] ext_irq_pin,
  input wire logic core_level_load,
  input wire logic [3:0] core_level_value,
  input wire logic disable_instr_active_in,
  output logic [3:0] priority_level,
  output logic nesting_disable,
  output logic alternate_vector_select,
  output logic [NUM_EXT-1:0] ext_irq_req,
  output logic user_irq_blocked,
  output logic irq
);

  // ********************************************************************
  // Decode
  // ********************************************************************
  logic wr_cc, wr_ic1, wr_ic2, wr_sr, wr_evs, wr_evm;
  assign wr_cc = reg_wr && (reg_addr == CORE_CONTROL_OFS);
  assign wr_ic1 = reg_wr && (reg_addr == INTERRUPT_CONTROL_ONE_OFS);
  assign wr_ic2 = reg_wr && (reg_addr == INTERRUPT_CONTROL_TWO_OFS);
  assign wr_sr = reg_wr && (reg_addr == ARITH_STATUS_OFS);
  assign wr_evs = reg_wr && (reg_addr == EVENT_STATUS_OFS);
  assign wr_evm = reg_wr && (reg_addr == EVENT_MASK_OFS);

  // ********************************************************************
  // Processor priority level
  // ********************************************************************
  logic top_q, top_d;
  logic [2:0] low_q, low_d;
  logic blocked_q;

  always_comb begin
    top_d = top_q;
    low_d = low_q;
    if (wr_cc && !reg_wdata[CC_TOP_BIT]) begin
      top_d = 1'b0;
    end
    if (wr_sr && !nesting_disable) begin
      low_d = reg_wdata[SR_IPL_MSB:SR_IPL_LSB];
    end
    // The core's own load wins, so a trap level cannot be undone by a
    // software write landing in the same cycle.
    if (core_level_load) begin
      {top_d, low_d} = core_level_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      {top_q, low_q} <= LEVEL_RESET;
      blocked_q <= 1'b0;
    end else begin
      top_q <= top_d;
      low_q <= low_d;
      blocked_q <= (low_d == LOW_BITS_USER_OFF);
    end
  end

  assign priority_level = {top_q, low_q};
  assign user_irq_blocked = blocked_q;

  // ********************************************************************
  // First control register
  // ********************************************************************
  logic nest_q;
  logic [NUM_TRAP-1:0] trap_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nest_q <= 1'b0;
    end else if (wr_ic1) begin
      nest_q <= reg_wdata[IC1_NEST_BIT];
    end
  end

  // A trap arriving in the cycle of a clearing write still sets its flag.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trap_q <= TRAP_RESET;
    end else if (wr_ic1) begin
      trap_q <= reg_wdata[IC1_TRAP_MSB:IC1_TRAP_LSB] | trap_event;
    end else begin
      trap_q <= trap_q | trap_event;
    end
  end

  assign nesting_disable = nest_q;

  // ********************************************************************
  // Second control register
  // ********************************************************************
  logic alt_q, disable_instruction_active_q;
  logic [NUM_EXT-1:0] pol_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      alt_q <= 1'b0;
      pol_q <= POL_RESET;
    end else if (wr_ic2) begin
      alt_q <= reg_wdata[IC2_ALT_BIT];
      pol_q <= reg_wdata[IC2_POL_MSB:IC2_POL_LSB];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      disable_instruction_active_q <= 1'b0;
    end else begin
      disable_instruction_active_q <= disable_instr_active_in;
    end
  end

  assign alternate_vector_select = alt_q;

  // ********************************************************************
  // External edge detection
  // ********************************************************************
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_EXT-1:0] ext_req_q;

  generate
    for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
      logic s1_q, s2_q, s3_q, lvl_q;
      logic change;
      // The settled level starts low, so a pin already high at reset
      // shows up as one rising edge after release.
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= ext_irq_pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign change = (s2_q == s3_q) && (s3_q != lvl_q);
      assign ext_edge[i] = change && (pol_q[i] ? !s3_q : s3_q);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ext_req_q <= POL_RESET;
    end else begin
      ext_req_q <= ext_edge;
    end
  end

  assign ext_irq_req = ext_req_q;

  // ********************************************************************
  // Event status, mask and interrupt line
  // ********************************************************************
  logic [EV_W-1:0] ev_q, mask_q, ev_set;
  logic irq_q;

  assign ev_set = {trap_event, ext_edge};

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ev_q <= EV_RESET;
    end else if (wr_evs) begin
      ev_q <= (ev_q & ~reg_wdata[EV_W-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mask_q <= EV_RESET;
    end else if (wr_evm) begin
      mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_q & mask_q);
    end
  end

  assign irq = irq_q;

  // ********************************************************************
  // Read port
  // ********************************************************************
  logic [DATA_W-1:0] rd_d, rdata_q;

  always_comb begin
    rd_d = DATA_ZERO;
    case (reg_addr)
      CORE_CONTROL_OFS: begin
        rd_d[CC_TOP_BIT] = top_q;
        rd_d[CC_RSVD_BIT] = 1'b1;
      end
      INTERRUPT_CONTROL_ONE_OFS: begin
        rd_d[IC1_NEST_BIT] = nest_q;
        rd_d[IC1_TRAP_MSB:IC1_TRAP_LSB] = trap_q;
      end
      INTERRUPT_CONTROL_TWO_OFS: begin
        rd_d[IC2_ALT_BIT] = alt_q;
        rd_d[IC2_DISABLE_INSTRUCTION_ACTIVE_BIT] = disable_instruction_active_q;
        rd_d[IC2_POL_MSB:IC2_POL_LSB] = pol_q;
      end
      ARITH_STATUS_OFS: rd_d[SR_IPL_MSB:SR_IPL_LSB] = low_q;
      EVENT_STATUS_OFS: rd_d[EV_W-1:0] = ev_q;
      EVENT_MASK_OFS: rd_d[EV_W-1:0] = mask_q;
      default: rd_d = DATA_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= DATA_ZERO;
    end else if (reg_rd) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= DATA_ZERO;
    end
  end

  assign reg_rdata = rdata_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence sw_clear_top;
    wr_cc && !reg_wdata[CC_TOP_BIT] && !core_level_load;
  endsequence

  sequence locked_sr_write;
    wr_sr && nesting_disable && !core_level_load;
  endsequence

  chk_core_load: assert property (
    core_level_load |=> priority_level == $past(core_level_value))
    else $error("priority level did not follow core load");

  chk_top_no_set: assert property (
    wr_cc && !core_level_load |=>
      priority_level[3] == ($past(top_q) & $past(reg_wdata[CC_TOP_BIT])))
    else $error("software changed top priority bit wrongly");

  chk_top_clear: assert property (
    sw_clear_top ##1 1'b1 |-> priority_level <= LEVEL_TOP_THRESHOLD)
    else $error("level above seven after top bit clear");

  chk_cc_readback: assert property (
    reg_rd && reg_addr == CORE_CONTROL_OFS |=>
      reg_rdata[CC_RSVD_BIT] && reg_rdata[15:4] == 12'h000 &&
      reg_rdata[1:0] == 2'h0)
    else $error("core control read value wrong");

  chk_sr_locked: assert property (
    locked_sr_write |=> priority_level[2:0] == $past(low_q))
    else $error("low priority bits changed while locked");

  chk_nest_write: assert property (
    wr_ic1 |=> nesting_disable == $past(reg_wdata[IC1_NEST_BIT]))
    else $error("nesting disable did not take write");

  chk_trap_sets: assert property (
    trap_event[3] |=> trap_q[3] ##1 (trap_q[3] || $past(wr_ic1)))
    else $error("arithmetic trap flag not set");

  chk_trap_sticky: assert property (
    trap_q[0] && !wr_ic1 |=> trap_q[0])
    else $error("trap flag dropped without write");

  chk_blocked: assert property (
    user_irq_blocked == (priority_level[2:0] == LOW_BITS_USER_OFF))
    else $error("user block does not match low bits");

  chk_ext_req: assert property (
    ext_irq_req[0] |-> $past(ext_edge[0]) && $past(g_ext[0].s3_q) ==
      !$past(pol_q[0]))
    else $error("external request on wrong edge");

  chk_alt_write: assert property (
    wr_ic2 |=> alternate_vector_select == $past(reg_wdata[IC2_ALT_BIT]))
    else $error("vector table select did not take write");

endmodule // cit_trap_control

// file: cit_core_model.sv
`timescale 1ns/10ps
module cit_core_model
  import cit_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [2:0] cmd_kind,
  input wire logic [4:0] cmd_arg,
  output logic [NUM_TRAP-1:0] trap_event,
  output logic [NUM_EXT-1:0] ext_irq_pin,
  output logic core_level_load,
  output logic [3:0] core_level_value,
  output logic disable_instr_active_in
);
  // ****
  // Core and trap source side
  // ****
  // Commands: 1 trap pulse, 2 level load, 3 pin levels, 4 disable status.
  // A trap is one pulse only, so a flag that is still set later is sticky.
  // Outputs change at the same edge that samples a command.
  initial begin
    trap_event = 4'h0;
    ext_irq_pin = 5'h00;
    core_level_load = 1'b0;
    core_level_value = 4'h0;
    disable_instr_active_in = 1'b0;
    forever begin
      @(posedge ref_clk);
      trap_event <= (cmd_kind == 3'h1) ? 4'(4'h1 << cmd_arg[1:0]) : 4'h0;
      core_level_load <= (cmd_kind == 3'h2);
      if (cmd_kind == 3'h2) core_level_value <= cmd_arg[3:0];
      if (cmd_kind == 3'h3) ext_irq_pin <= cmd_arg;
      if (cmd_kind == 3'h4) disable_instr_active_in <= cmd_arg[0];
    end
  end
endmodule // cit_core_model

// file: tb.sv
`timescale 1ns/10ps
module tb
  import cit_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } cit_row_type;
  cit_row_type rows [7] = '{
    '{4'h0, 16'hFFFF, 16'h0004}, '{4'h1, 16'hFFFF, 16'h801E},
    '{4'h1, 16'h0000, 16'h0000}, '{4'h2, 16'hFFFF, 16'h801F},
    '{4'h2, 16'h0000, 16'h0000}, '{4'h3, 16'hFFFF, 16'h00E0},
    '{4'h6, 16'hFFFF, 16'h0000}};
  logic ref_clk, resetn, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [3:0] trap_event, core_level_value, priority_level;
  logic [4:0] ext_irq_pin, ext_irq_req;
  logic core_level_load, disable_instr_active_in, nesting_disable;
  logic alternate_vector_select, user_irq_blocked, irq;
  logic [2:0] cmd_kind;
  logic [4:0] cmd_arg;
  int fail_count, n_compared;
  cit_trap_control cit_trap_control_i (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trap_event(trap_event),
    .ext_irq_pin(ext_irq_pin), .core_level_load(core_level_load),
    .core_level_value(core_level_value),
    .disable_instr_active_in(disable_instr_active_in),
    .priority_level(priority_level), .nesting_disable(nesting_disable),
    .alternate_vector_select(alternate_vector_select),
    .ext_irq_req(ext_irq_req), .user_irq_blocked(user_irq_blocked),
    .irq(irq));
  cit_core_model cit_core_model_i (.ref_clk(ref_clk),
    .cmd_kind(cmd_kind), .cmd_arg(cmd_arg),
    .trap_event(trap_event), .ext_irq_pin(ext_irq_pin),
    .core_level_load(core_level_load), .core_level_value(core_level_value),
    .disable_instr_active_in(disable_instr_active_in));
  // ****
  // Bus and compare tasks
  // ****
  task automatic check(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One command cycle to the far side model.
  task automatic core(input logic [2:0] k, input logic [4:0] v);
    @(posedge ref_clk);
    cmd_kind <= k;
    cmd_arg <= v;
    @(posedge ref_clk);
    cmd_kind <= 3'h0;
  endtask
  // Read data stand one cycle only, so they are taken right after the edge.
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("reg%0h", a), reg_rdata, e);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("irq", 16'(irq), 16'(v));
    if (n >= 10) results();
  endtask
  task automatic watch(input logic [4:0] e);
    logic [4:0] s;
    s = 5'h00;
    repeat (8) begin
      @(posedge ref_clk);
      #1 s = s | ext_irq_req;
    end
    check("ext", 16'(s), 16'(e));
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    cmd_kind = 3'h0;
    cmd_arg = 5'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rc(rows[k].a, rows[k].e);
    end
    $display("test registers done");
    core(3'h2, 5'h0A);
    rc(CORE_CONTROL_OFS, 16'h000C);
    rc(ARITH_STATUS_OFS, 16'h0040);
    wr(CORE_CONTROL_OFS, 16'h0000);
    rc(CORE_CONTROL_OFS, 16'h0004);
    check("lvl", 16'(priority_level), 16'h0002);
    core(3'h2, 5'h07);
    rc(CORE_CONTROL_OFS, 16'h0004);
    check("blk", 16'(user_irq_blocked), 16'h0001);
    wr(INTERRUPT_CONTROL_ONE_OFS, 16'h8000);
    #1 check("nest", 16'(nesting_disable), 16'h0001);
    wr(ARITH_STATUS_OFS, 16'h0000);
    rc(ARITH_STATUS_OFS, 16'h00E0);
    wr(INTERRUPT_CONTROL_ONE_OFS, 16'h0000);
    wr(ARITH_STATUS_OFS, 16'h0000);
    rc(ARITH_STATUS_OFS, 16'h0000);
    check("blk", 16'(user_irq_blocked), 16'h0000);
    $display("test priority done");
    for (int i = 0; i < NUM_TRAP; i++) begin
      wr(EVENT_MASK_OFS, 16'h0000);
      core(3'h1, 5'(i));
      repeat (3) @(posedge ref_clk);
      #1 check("irq", 16'(irq), 16'h0000);
      rc(INTERRUPT_CONTROL_ONE_OFS, 16'h0001 << (IC1_TRAP_LSB + i));
      wr(EVENT_MASK_OFS, 16'h0001 << (EV_TRAP_LSB + i));
      wait_irq(1'b1);
      wr(EVENT_STATUS_OFS, 16'h0001 << (EV_TRAP_LSB + i));
      wait_irq(1'b0);
      wr(INTERRUPT_CONTROL_ONE_OFS, 16'h0000);
      rc(INTERRUPT_CONTROL_ONE_OFS, 16'h0000);
    end
    $display("test traps done");
    wr(EVENT_MASK_OFS, 16'h001F);
    core(3'h3, 5'h1F);
    watch(5'h1F);
    rc(EVENT_STATUS_OFS, 16'h001F);
    wait_irq(1'b1);
    wr(INTERRUPT_CONTROL_TWO_OFS, 16'h001F);
    wr(EVENT_STATUS_OFS, 16'h001F);
    wait_irq(1'b0);
    core(3'h3, 5'h00);
    watch(5'h1F);
    core(3'h3, 5'h1F);
    watch(5'h00);
    wr(INTERRUPT_CONTROL_TWO_OFS, 16'h8000);
    #1 check("alt", 16'(alternate_vector_select), 16'h0001);
    core(3'h4, 5'h01);
    rc(INTERRUPT_CONTROL_TWO_OFS, 16'hC000);
    core(3'h4, 5'h00);
    core(3'h3, 5'h00);
    $display("test pins done");
    // Pins are low before reset, since a high pin would give an edge.
    core(3'h2, 5'h0A);
    wr(INTERRUPT_CONTROL_ONE_OFS, 16'h801E);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      rc(4'(a), (a == 0) ? 16'h0004 : 16'h0000);
    end
    check("lvl", 16'(priority_level), 16'h0000);
    check("alt", 16'(alternate_vector_select), 16'h0000);
    $display("test reset done");
    results();
  end
endmodule // tb
